/* include/iorq_consts.svh */
// constants of the request control and data channel block
// assumes a 100 MHz system clock; data line n is bit n of every word
`ifndef IORQ_CONSTS_SVH
`define IORQ_CONSTS_SVH

// function codes driven to the peripheral
`define IORQ_FC_NONE 4'h0
`define IORQ_FC_CHAN_ADDR 4'h1
`define IORQ_FC_CHAN_DIN 4'h2
`define IORQ_FC_CHAN_DOUT 4'h3
`define IORQ_FC_MASK_OUT 4'h4
`define IORQ_FC_DATA_OUT 4'h5

// widths
`define IORQ_DATA_W 16
`define IORQ_ADDR_W 15
`define IORQ_CNT_W 16
`define IORQ_FC_W 4
`define IORQ_FC_CNT_W 5

// timing: each function code is held this long
`define IORQ_CLK_MHZ 100
`define IORQ_FC_TIME_NS 240
`define IORQ_FC_CYC ((`IORQ_FC_TIME_NS * `IORQ_CLK_MHZ + 999) / 1000)

// fields of the word on the data lines
`define IORQ_DIR_BIT 0
`define IORQ_INIT_BUSY_DONE_BIT 7
`define IORQ_INIT_REG_SEL_BIT 8
`define IORQ_INIT_POL_BIT 9

// reset values and the last count
`define IORQ_ADDR_RST 15'h0000
`define IORQ_CNT_RST 16'h0000
`define IORQ_WORD_RST 16'h0000
`define IORQ_CNT_LAST 16'hffff

`endif

/* include/iorq_pkg.sv */
// types shared by the request control and data channel block
// assumes nothing of its surroundings
package iorq_pkg;

  typedef enum logic [2:0] {
    IORQ_IDLE = 3'h0,
    IORQ_LOAD_T = 3'h1,
    IORQ_SEND = 3'h2,
    IORQ_WAIT_W = 3'h3,
    IORQ_XFER = 3'h4,
    IORQ_MASK = 3'h5,
    IORQ_DOUT = 3'h6
  } iorq_state_t;

endpackage

/* logic/iorq_chan.sv */
// request control and data channel logic of an i/o controller
// assumes command and instruction strobes arrive decoded on SYS_CLK_I
`timescale 1ns/10ps
`default_nettype none
`include "iorq_consts.svh"

module iorq_chan (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // decoded cpu commands, one-cycle pulses
  input wire logic REQ_ENABLE_I,
  input wire logic CHAN_ADDR_REQ_I,
  input wire logic INIT_I,
  input wire logic MASK_OUT_I,
  input wire logic ADDR_LOAD_I,
  input wire logic COUNT_LOAD_I,
  input wire logic ADDR_READ_I,
  input wire logic INT_HONOR_I,
  input wire logic [`IORQ_DATA_W-1:0] CPU_DATA_I,
  // channel data word from the cpu for out transfers
  input wire logic CHAN_WVALID_I,
  input wire logic [`IORQ_DATA_W-1:0] CHAN_WDATA_I,
  // busy/done state
  input wire logic DONE_I,
  // words toward the cpu
  output logic CTL_VALID_O,
  output logic [`IORQ_DATA_W-1:0] CTL_WORD_O,
  output logic RD_VALID_O,
  output logic [`IORQ_DATA_W-1:0] RD_DATA_O,
  output logic BLOCK_DONE_O,
  // request and priority pins
  input wire logic CHAN_SYNC_I,
  input wire logic INT_SYNC_I,
  input wire logic CHAN_PRI_I,
  input wire logic INT_PRI_I,
  output logic CHAN_REQ_O,
  output logic INT_REQ_O,
  output logic CHAN_PRI_O,
  output logic INT_PRI_O,
  // peripheral port
  output logic [`IORQ_FC_W-1:0] FC_O,
  input wire logic [`IORQ_DATA_W-1:0] PD_I,
  output logic [`IORQ_DATA_W-1:0] PD_O,
  output logic PD_OE_O,
  // initialisation settings
  output logic EXT_BUSY_DONE_O,
  output logic INT_REGS_O
);

  logic [3:0] ctl_s;
  logic [`IORQ_DATA_W-1:0] pd_s;
  iorq_pkg::iorq_state_t st_q, st_d;
  logic [`IORQ_FC_CNT_W-1:0] fc_cnt_q;
  logic [`IORQ_FC_W-1:0] fc_q, fc_d;
  logic chreq_q, int_req_q, honor_q, int_dis_q, reload_q, pend_q, dir_q;
  logic pol_q, int_regs_q, ext_bd_q, ctl_valid_q, rd_valid_q, blk_q;
  logic [`IORQ_DATA_W-1:0] t_q, out_q, rd_q, mask_q;
  logic [`IORQ_ADDR_W-1:0] addr_q;
  logic [`IORQ_CNT_W-1:0] cnt_q;

  iorq_sync2 #(.WIDTH(4)) u_sync_ctl (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .async_i({CHAN_SYNC_I, INT_SYNC_I, CHAN_PRI_I, INT_PRI_I}),
    .sync_o(ctl_s)
  );

  iorq_sync2 #(.WIDTH(`IORQ_DATA_W)) u_sync_pd (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .async_i(PD_I),
    .sync_o(pd_s)
  );

  wire chan_sync = ctl_s[3];
  wire int_sync = ctl_s[2];
  wire chan_has_pri;

  iorq_pri_node u_pri_chan (
    .pri_i(ctl_s[1]),
    .pri_o(CHAN_PRI_O),
    .want_i(chreq_q),
    .has_pri_o(chan_has_pri)
  );

  iorq_pri_node u_pri_int (
    .pri_i(ctl_s[0]),
    .pri_o(INT_PRI_O),
    .want_i(int_req_q),
    .has_pri_o()
  );

  // decode
  wire idle = (st_q == iorq_pkg::IORQ_IDLE);
  wire cmd = REQ_ENABLE_I | CHAN_ADDR_REQ_I;
  wire fc_done = (fc_cnt_q == `IORQ_FC_CNT_W'(`IORQ_FC_CYC - 1));
  wire neg = pol_q | (fc_q == `IORQ_FC_MASK_OUT);
  wire [`IORQ_DATA_W-1:0] pd_val = pd_s ^ {`IORQ_DATA_W{neg}};
  wire serve = CHAN_ADDR_REQ_I & chan_has_pri & chreq_q & idle;
  wire start_load = cmd & ~chreq_q & chan_sync & idle;
  wire int_cause = DONE_I | int_sync;
  wire mask_hit = |(mask_q & pd_val);
  // direction is still in the buffer when leaving the send state
  wire xfer_dir = (st_q == iorq_pkg::IORQ_SEND) ? t_q[`IORQ_DIR_BIT] :
                  dir_q;
  wire [`IORQ_ADDR_W-1:0] addr_inc = addr_q + `IORQ_ADDR_W'(1);
  wire [`IORQ_ADDR_W-1:0] addr_t = reload_q ? addr_inc : addr_q;
  wire [`IORQ_ADDR_W-1:0] t_addr = int_regs_q ? addr_t : pd_val[15:1];
  wire xfer_end = (st_q == iorq_pkg::IORQ_XFER) & fc_done;
  wire load_end = (st_q == iorq_pkg::IORQ_LOAD_T) & fc_done;
  wire last_word = (cnt_q == `IORQ_CNT_LAST);
  wire [`IORQ_DATA_W-1:0] addr_word = {addr_q, 1'b0};

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      iorq_pkg::IORQ_IDLE: begin
        if (serve) begin
          st_d = iorq_pkg::IORQ_SEND;
        end else if (start_load) begin
          st_d = iorq_pkg::IORQ_LOAD_T;
        end else if (MASK_OUT_I) begin
          st_d = iorq_pkg::IORQ_MASK;
        end else if (ADDR_LOAD_I | COUNT_LOAD_I) begin
          st_d = iorq_pkg::IORQ_DOUT;
        end
      end
      iorq_pkg::IORQ_LOAD_T: begin
        if (fc_done) begin
          if (!pend_q) begin
            st_d = iorq_pkg::IORQ_IDLE;
          end else if (dir_q) begin
            st_d = iorq_pkg::IORQ_XFER;
          end else begin
            st_d = iorq_pkg::IORQ_WAIT_W;
          end
        end
      end
      iorq_pkg::IORQ_SEND: begin
        // reload before the data word goes
        if (chan_sync) begin
          st_d = iorq_pkg::IORQ_LOAD_T;
        end else if (t_q[`IORQ_DIR_BIT]) begin
          st_d = iorq_pkg::IORQ_XFER;
        end else begin
          st_d = iorq_pkg::IORQ_WAIT_W;
        end
      end
      iorq_pkg::IORQ_WAIT_W: begin
        if (CHAN_WVALID_I) begin
          st_d = iorq_pkg::IORQ_XFER;
        end
      end
      iorq_pkg::IORQ_XFER,
      iorq_pkg::IORQ_MASK,
      iorq_pkg::IORQ_DOUT: begin
        if (fc_done) begin
          st_d = iorq_pkg::IORQ_IDLE;
        end
      end
      default: begin
        st_d = iorq_pkg::IORQ_IDLE;
      end
    endcase
  end

  // function code follows the state
  always_comb begin
    case (st_d)
      iorq_pkg::IORQ_LOAD_T: fc_d = `IORQ_FC_CHAN_ADDR;
      iorq_pkg::IORQ_XFER: fc_d = xfer_dir ? `IORQ_FC_CHAN_DIN :
                                             `IORQ_FC_CHAN_DOUT;
      iorq_pkg::IORQ_MASK: fc_d = `IORQ_FC_MASK_OUT;
      iorq_pkg::IORQ_DOUT: fc_d = `IORQ_FC_DATA_OUT;
      default: fc_d = `IORQ_FC_NONE;
    endcase
  end

  // sequencer
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= iorq_pkg::IORQ_IDLE;
      fc_q <= `IORQ_FC_NONE;
      fc_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      fc_q <= fc_d;
      fc_cnt_q <= (st_d != st_q) ? '0 : fc_cnt_q + `IORQ_FC_CNT_W'(1);
    end
  end

  // channel request flag, buffer and direction
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      chreq_q <= 1'b0;
      reload_q <= 1'b0;
      pend_q <= 1'b0;
      dir_q <= 1'b0;
      t_q <= `IORQ_WORD_RST;
    end else if (INIT_I) begin
      chreq_q <= 1'b0;
      reload_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (start_load) begin
        chreq_q <= 1'b1;
        reload_q <= 1'b0;
        pend_q <= 1'b0;
      end
      if (st_q == iorq_pkg::IORQ_SEND) begin
        dir_q <= t_q[`IORQ_DIR_BIT];
        pend_q <= 1'b1;
        reload_q <= chan_sync;
        if (!chan_sync) begin
          chreq_q <= 1'b0;
        end
      end
      if (load_end) begin
        t_q <= {t_addr, pd_val[`IORQ_DIR_BIT]};
      end
      if (xfer_end) begin
        pend_q <= 1'b0;
      end
    end
  end

  // interrupt request, honour and disable flags
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      int_req_q <= 1'b0;
      honor_q <= 1'b0;
      int_dis_q <= 1'b0;
      mask_q <= `IORQ_WORD_RST;
    end else if (INIT_I) begin
      int_req_q <= 1'b0;
      honor_q <= 1'b0;
      int_dis_q <= 1'b0;
    end else begin
      if (cmd) begin
        int_req_q <= ~honor_q & int_cause & ~int_dis_q;
      end
      // a new honour in the command cycle waits for the next command
      honor_q <= INT_HONOR_I | (honor_q & ~cmd);
      // mask comes with the instruction, the lines are read at the end
      if (idle && (st_d == iorq_pkg::IORQ_MASK)) begin
        mask_q <= CPU_DATA_I;
      end
      if ((st_q == iorq_pkg::IORQ_MASK) && fc_done) begin
        int_dis_q <= mask_hit;
      end
    end
  end

  // internal registers, settings and answer words
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      addr_q <= `IORQ_ADDR_RST;
      cnt_q <= `IORQ_CNT_RST;
      pol_q <= 1'b0;
      int_regs_q <= 1'b0;
      ext_bd_q <= 1'b0;
      out_q <= `IORQ_WORD_RST;
      rd_q <= `IORQ_WORD_RST;
      rd_valid_q <= 1'b0;
      ctl_valid_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      ctl_valid_q <= serve;
      blk_q <= 1'b0;
      if (INIT_I) begin
        addr_q <= `IORQ_ADDR_RST;
        cnt_q <= `IORQ_CNT_RST;
        ext_bd_q <= ~pd_s[`IORQ_INIT_BUSY_DONE_BIT];
        int_regs_q <= pd_s[`IORQ_INIT_REG_SEL_BIT];
        pol_q <= pd_s[`IORQ_INIT_POL_BIT];
      end else if (idle && (ADDR_LOAD_I | COUNT_LOAD_I) && !serve &&
                   !start_load && !MASK_OUT_I) begin
        out_q <= CPU_DATA_I;
        if (int_regs_q && ADDR_LOAD_I) begin
          addr_q <= CPU_DATA_I[15:1];
        end
        if (int_regs_q && COUNT_LOAD_I) begin
          cnt_q <= CPU_DATA_I;
        end
      end else if (idle && ADDR_READ_I) begin
        rd_q <= int_regs_q ? addr_word : pd_val;
        rd_valid_q <= 1'b1;
      end else if ((st_q == iorq_pkg::IORQ_WAIT_W) && CHAN_WVALID_I) begin
        out_q <= CHAN_WDATA_I;
      end else if (xfer_end) begin
        if (dir_q) begin
          rd_q <= pd_val;
          rd_valid_q <= 1'b1;
        end
        if (int_regs_q) begin
          addr_q <= addr_inc;
          cnt_q <= cnt_q + `IORQ_CNT_W'(1);
          blk_q <= last_word;
        end
      end
    end
  end

  // outputs
  assign CHAN_REQ_O = chreq_q;
  assign INT_REQ_O = int_req_q;
  assign FC_O = fc_q;
  assign PD_O = out_q ^ {`IORQ_DATA_W{pol_q}};
  assign PD_OE_O = (st_q == iorq_pkg::IORQ_DOUT) |
                   ((st_q == iorq_pkg::IORQ_XFER) & ~dir_q);
  assign CTL_VALID_O = ctl_valid_q;
  assign CTL_WORD_O = t_q;
  assign RD_VALID_O = rd_valid_q;
  assign RD_DATA_O = rd_q;
  assign BLOCK_DONE_O = blk_q;
  assign EXT_BUSY_DONE_O = ext_bd_q;
  assign INT_REGS_O = int_regs_q;

  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_NEG_LOGIC: assert property (
    (fc_q == `IORQ_FC_MASK_OUT) |-> (pd_val == ~pd_s))
    else $error("mask-out data not read inverted");
  AST_CHREQ_SET: assert property (
    start_load && !INIT_I |=> CHAN_REQ_O ##1 (FC_O == `IORQ_FC_CHAN_ADDR))
    else $error("channel request or address code missing");
  AST_SEND_FIRST: assert property (
    serve && !INIT_I |=> CTL_VALID_O && (CTL_WORD_O == $past(t_q)))
    else $error("control word not sent first");
  AST_SEND_CLEAR: assert property (
    (st_q == iorq_pkg::IORQ_SEND) && !chan_sync && !INIT_I |=> !CHAN_REQ_O)
    else $error("channel request not cleared");
  AST_RELOAD: assert property (
    (st_q == iorq_pkg::IORQ_SEND) && chan_sync |=>
      (FC_O == `IORQ_FC_CHAN_ADDR) [*8])
    else $error("buffer reload code not issued");
  AST_INT_SET: assert property (
    cmd && !INIT_I && !honor_q && int_cause && !int_dis_q |=> INT_REQ_O)
    else $error("interrupt request not raised");
  AST_INT_CLEAR: assert property (
    cmd && honor_q |=> !INT_REQ_O)
    else $error("interrupt request not dropped");
  AST_INT_STABLE: assert property (
    !cmd && !INIT_I |=> $stable(INT_REQ_O))
    else $error("interrupt request moved without command");
  AST_MASK: assert property (
    (st_q == iorq_pkg::IORQ_MASK) && fc_done && !INIT_I |=>
      (int_dis_q == $past(mask_hit)))
    else $error("interrupt disable wrong after mask-out");
  AST_COUNT: assert property (
    xfer_end && int_regs_q && !INIT_I |=>
      (cnt_q == $past(cnt_q) + `IORQ_CNT_W'(1)) && (addr_q == $past(addr_inc)))
    else $error("counters did not advance");
  AST_BLOCK: assert property (
    BLOCK_DONE_O |-> (cnt_q == `IORQ_CNT_RST))
    else $error("block end without counter overflow");
  AST_INIT: assert property (
    INIT_I |=> !CHAN_REQ_O && !INT_REQ_O && !int_dis_q && (cnt_q == '0))
    else $error("initialisation left state set");

endmodule

`default_nettype wire

/* logic/iorq_pri_node.sv */
// one node of a daisy-chained priority line
// assumes the incoming priority level is already synchronised
`timescale 1ns/10ps
`default_nettype none

module iorq_pri_node (
  // chain
  input wire logic pri_i,
  output logic pri_o,
  // local request and grant
  input wire logic want_i,
  output logic has_pri_o
);

  // priority is held only while the incoming line is high
  assign has_pri_o = pri_i;
  // a requesting node blocks everything further down
  assign pri_o = pri_i & ~want_i;

endmodule

`default_nettype wire

/* logic/iorq_sync2.sv */
// two flip-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to SYS_CLK_I
`timescale 1ns/10ps
`default_nettype none

module iorq_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and their synchronised copies
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

`default_nettype wire

/* test/iorq_periph.sv */
// peripheral model on the far side of the channel's peripheral port
// assumes the bench sets its sync request and the words it answers with
`timescale 1ns/10ps
`default_nettype none
`include "iorq_consts.svh"

module iorq_periph (
  // clock and function code from the controller
  input wire logic clk_i,
  input wire logic [`IORQ_FC_W-1:0] fc_i,
  // bench controls
  input wire logic set_i,
  input wire logic more_i,
  input wire logic hold_i,
  input wire logic [`IORQ_DATA_W-1:0] hold_val_i,
  input wire logic [`IORQ_DATA_W-1:0] ctl_i,
  input wire logic [`IORQ_DATA_W-1:0] data_i,
  input wire logic [`IORQ_DATA_W-1:0] mask_i,
  // pins toward the controller
  output logic sync_o,
  output logic [`IORQ_DATA_W-1:0] pd_o
);
  logic [`IORQ_DATA_W-1:0] last_q = 16'h0000;
  logic [`IORQ_FC_W-1:0] fc_q = 4'h0;
  logic sync_q = 1'b0;
  wire logic is_addr = (fc_i == `IORQ_FC_CHAN_ADDR);
  wire logic is_din = (fc_i == `IORQ_FC_CHAN_DIN);
  wire logic is_mask = (fc_i == `IORQ_FC_MASK_OUT);
  // released lines show the inverse of the last value, or hold_val_i while hold_i is set
  assign pd_o = is_addr ? ctl_i :
    is_din ? data_i :
    is_mask ? ~mask_i : // selected line pulled low
    hold_i ? hold_val_i : ~last_q;
  assign sync_o = sync_q;
  always @(posedge clk_i) begin
    fc_q <= fc_i;
    last_q <= pd_o;
    if (set_i) begin
      sync_q <= 1'b1;
    end else if (is_addr && fc_q != `IORQ_FC_CHAN_ADDR) begin
      sync_q <= more_i; // release unless another transfer
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the request control and data channel block
// assumes the peripheral model of iorq_periph stands on the port
`timescale 1ns/10ps
`default_nettype none
`include "iorq_consts.svh"

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic re = 1'b0, car = 1'b0, init = 1'b0, mo = 1'b0;
  logic al = 1'b0, cl = 1'b0, ar = 1'b0, ih = 1'b0;
  logic done = 1'b0, int_sync = 1'b0, chan_pri = 1'b1;
  logic set = 1'b0, more = 1'b0, hold = 1'b0, bd_seen = 1'b0;
  logic wv = 1'b0;
  logic [15:0] ctl = 16'h0021, wdata = 16'h0000, hold_val = 16'h0180;
  logic [15:0] cpu_data = 16'h0000, mask = 16'h0000;
  logic ctl_valid, rd_valid, block_done, chan_req, int_req;
  logic chan_pri_o, int_pri_o, pd_oe, ext_bd, int_regs, chan_sync;
  logic [15:0] ctl_word, rd_data, pd_in, pd_out;
  logic [3:0] fc;
  int err_count = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (block_done === 1'b1) bd_seen <= 1'b1;

  iorq_chan dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REQ_ENABLE_I(re),
    .CHAN_ADDR_REQ_I(car), .INIT_I(init), .MASK_OUT_I(mo),
    .ADDR_LOAD_I(al), .COUNT_LOAD_I(cl), .ADDR_READ_I(ar),
    .INT_HONOR_I(ih), .CPU_DATA_I(cpu_data), .CHAN_WVALID_I(wv),
    .CHAN_WDATA_I(wdata), .DONE_I(done), .CTL_VALID_O(ctl_valid),
    .CTL_WORD_O(ctl_word), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
    .BLOCK_DONE_O(block_done), .CHAN_SYNC_I(chan_sync),
    .INT_SYNC_I(int_sync), .CHAN_PRI_I(chan_pri), .INT_PRI_I(1'b1),
    .CHAN_REQ_O(chan_req), .INT_REQ_O(int_req), .CHAN_PRI_O(chan_pri_o),
    .INT_PRI_O(int_pri_o), .FC_O(fc), .PD_I(pd_in), .PD_O(pd_out),
    .PD_OE_O(pd_oe), .EXT_BUSY_DONE_O(ext_bd), .INT_REGS_O(int_regs));

  iorq_periph periph (.clk_i(clk), .fc_i(fc), .set_i(set), .more_i(more),
    .hold_i(hold), .hold_val_i(hold_val), .ctl_i(ctl),
    .data_i(16'h5a3c), .mask_i(mask), .sync_o(chan_sync), .pd_o(pd_in));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_up(string name);
    err_count++;
    $display("[FAIL] %s expected event seen none", name);
    report_and_stop();
  endtask

  task automatic wait_fc(logic [3:0] v);
    int i;
    for (i = 0; i < 80 && fc !== v; i++) tick();
    if (fc !== v) give_up("function code");
  endtask

  task automatic wait_rd();
    int i;
    for (i = 0; i < 80 && rd_valid !== 1'b1; i++) tick();
    if (rd_valid !== 1'b1) give_up("read valid");
  endtask

  task automatic t_reset();
    chk("chan req", 16'h0, chan_req);
    chk("int req", 16'h0, int_req);
    chk("fc", 16'h0, fc);
    chk("rd data", 16'h0, rd_data);
  endtask

  task automatic t_regs();
    hold = 1'b1;
    tick(4);
    pulse(init);
    tick(2);
    chk("internal regs", 16'h1, int_regs);
    chk("ext busy done", 16'h0, ext_bd);
    hold_val = 16'h0100; // busy/done flags kept outside
    tick(3);
    pulse(init);
    tick(2);
    hold = 1'b0;
    chk("ext busy done on", 16'h1, ext_bd);
    chk("internal regs 2", 16'h1, int_regs);
    cpu_data = 16'h0020;
    pulse(al);
    chk("addr load oe", 16'h1, pd_oe);
    chk("addr load pd", 16'h0020, pd_out);
    wait_fc(`IORQ_FC_NONE);
    cpu_data = 16'hffff;
    pulse(cl);
    chk("count load pd", 16'hffff, pd_out);
    wait_fc(`IORQ_FC_NONE);
    pulse(ar);
    wait_rd();
    chk("addr read", 16'h0020, rd_data);
  endtask

  task automatic t_chan();
    set = 1'b1;
    tick();
    set = 1'b0;
    tick(4);
    pulse(re);
    chk("chan req set", 16'h1, chan_req);
    chk("load code", `IORQ_FC_CHAN_ADDR, fc);
    chk("chan pri out", 16'h0, chan_pri_o);
    tick(192); // spacing after request enable
    chan_pri = 1'b0;
    tick(4);
    pulse(car);
    chk("no pri service", 16'h0, ctl_valid);
    chan_pri = 1'b1;
    tick(4);
    bd_seen = 1'b0;
    pulse(car);
    chk("ctl valid", 16'h1, ctl_valid);
    chk("ctl word", 16'h0021, ctl_word);
    tick();
    chk("chan req clear", 16'h0, chan_req);
    chk("data in code", `IORQ_FC_CHAN_DIN, fc);
    wait_rd();
    chk("chan data", 16'h5a3c, rd_data);
    tick(3);
    chk("block done", 16'h1, bd_seen);
    pulse(ar);
    wait_rd();
    chk("addr advanced", 16'h0022, rd_data);
  endtask

  task automatic t_reload();
    more = 1'b1;
    set = 1'b1;
    tick();
    set = 1'b0;
    tick(4);
    pulse(re);
    tick(192);
    pulse(car);
    chk("ctl valid 1", 16'h1, ctl_valid);
    tick();
    chk("reload code", `IORQ_FC_CHAN_ADDR, fc);
    chk("chan req held", 16'h1, chan_req);
    more = 1'b0;
    wait_fc(`IORQ_FC_CHAN_DIN);
    wait_rd();
    tick(4);
    // keep asking while the request stands
    pulse(car);
    chk("ctl valid 2", 16'h1, ctl_valid);
    chk("ctl word 2", 16'h0025, ctl_word);
    tick();
    chk("chan req drop", 16'h0, chan_req);
    wait_rd();
    chk("chan data 2", 16'h5a3c, rd_data);
  endtask

  task automatic t_out();
    ctl = 16'h0020;
    set = 1'b1;
    tick();
    set = 1'b0;
    tick(4);
    pulse(re);
    wait_fc(`IORQ_FC_NONE);
    tick(192);
    pulse(car);
    chk("out ctl valid", 16'h1, ctl_valid);
    chk("out ctl word", 16'h0026, ctl_word);
    tick();
    chk("out waits", `IORQ_FC_NONE, fc);
    wdata = 16'hc3a5;
    pulse(wv);
    chk("data out code", `IORQ_FC_CHAN_DOUT, fc);
    chk("out oe", 16'h1, pd_oe);
    chk("out data", 16'hc3a5, pd_out);
    wait_fc(`IORQ_FC_NONE);
  endtask

  task automatic t_int();
    int_sync = 1'b1; // cause held until honoured
    tick(4);
    pulse(re);
    chk("int req sync", 16'h1, int_req);
    chk("int pri out", 16'h0, int_pri_o);
    mask = 16'h0008;
    cpu_data = 16'h0008;
    pulse(mo);
    cpu_data = 16'h0000;
    wait_fc(`IORQ_FC_NONE);
    tick(2);
    pulse(re);
    chk("int masked", 16'h0, int_req);
    cpu_data = 16'h0004;
    tick();
    pulse(mo);
    wait_fc(`IORQ_FC_NONE);
    tick(2);
    pulse(re);
    chk("int unmasked", 16'h1, int_req);
    pulse(ih);
    pulse(re);
    chk("int honoured", 16'h0, int_req);
    int_sync = 1'b0;
    done = 1'b1;
    tick(4);
    pulse(re);
    chk("int req done", 16'h1, int_req);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(3);
    t_reset();
    t_regs();
    t_chan();
    t_reload();
    t_out();
    t_int();
    report_and_stop();
  end
endmodule
`default_nettype wire
